// ===== core/servo_flags_pkg.sv
package servo_flags_pkg;

    // ----------------------------------------
    // Register map (byte addresses, one word each)
    // ----------------------------------------
    localparam logic [11:0] ADDR_CONTROL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_MOTION_THRESH = 12'h008;
    localparam logic [11:0] ADDR_MATCH_BAND = 12'h00C;
    localparam logic [11:0] ADDR_SETTLE_WINDOW = 12'h010;
    localparam logic [11:0] ADDR_ALLOC = 12'h014;
    localparam logic [11:0] ADDR_COMMAND = 12'h018;
    localparam logic [11:0] ADDR_SPEED_REF = 12'h01C;
    localparam logic [11:0] ADDR_SPEED_ACT = 12'h020;
    localparam logic [11:0] ADDR_POS_ERR = 12'h024;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    // CONTROL: bit0 absolute scale, bit1 no hall sensor, bits3:2 settle timing select,
    // bits5:4 control mode
    localparam int CTL_ABS_SCALE = 0;
    localparam int CTL_NO_HALL = 1;
    localparam int CTL_SETTLE_LO = 2;
    localparam int CTL_MODE_LO = 4;
    // COMMAND: bit0 fault clear, bit1 sensor enable, bit2 sensor disable, bit3 servo enable
    localparam int CMD_FAULT_CLEAR = 0;
    localparam int CMD_SENSOR_ON = 1;
    localparam int CMD_SENSOR_OFF = 2;
    localparam int CMD_SERVO_ON = 3;
    // ALLOC: one enable bit per allocatable flag
    localparam int ALLOC_WARN = 0;
    localparam int ALLOC_MOTION = 1;
    localparam int ALLOC_READY = 2;
    localparam int ALLOC_MATCH = 3;
    localparam int ALLOC_SETTLED = 4;
    localparam int NUM_ALLOC = 5;

    // ----------------------------------------
    // Setting limits and reset values
    // ----------------------------------------
    localparam logic [31:0] MOTION_THRESH_MIN = 32'h0000_0001;
    localparam logic [31:0] MOTION_THRESH_MAX = 32'h0000_2710; // 10000 mm/s
    localparam logic [31:0] MOTION_THRESH_RST = 32'h0000_0014; // 20 mm/s
    localparam logic [31:0] MATCH_BAND_MAX = 32'h0000_0064;    // 100 mm/s
    localparam logic [31:0] MATCH_BAND_RST = 32'h0000_000A;    // 10 mm/s
    localparam logic [31:0] SETTLE_WINDOW_MAX = 32'h4000_0000; // 1073741824
    localparam logic [31:0] SETTLE_WINDOW_RST = 32'h0000_0007;
    localparam logic [1:0] SETTLE_SEL_RST = 2'h0;
    localparam logic [4:0] ALLOC_RST = 5'h00;

    typedef enum logic [1:0] {
        MODE_POSITION,
        MODE_SPEED,
        MODE_FORCE
    } ctrl_mode_t;

    // Drive conditions coming from the surrounding servo core
    typedef struct packed {
        logic main_power_on;
        logic power_block_active;
        logic fault_detect;
        logic warning_detect;
        logic polarity_done;
        logic panel_fault_reset;
        logic filtered_ref_zero;
        logic raw_ref_zero;
    } drive_cond_t;

    // Status flags, active high meaning "closed"
    typedef struct packed {
        logic fault_indicator;
        logic warning;
        logic motion_detected;
        logic drive_ready;
        logic speed_match;
        logic position_settled;
    } flags_t;

endpackage : servo_flags_pkg

// ===== core/abs_diff_cmp.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Registered |a - b| < limit compare
// ----------------------------------------
module abs_diff_cmp (
    input wire logic clk,
    input wire logic rstn,
    input wire logic signed [31:0] a,
    input wire logic signed [31:0] b,
    input wire logic [31:0] limit,
    output logic below
);
    typedef struct packed {
        logic below;
    } cmp_state_t;

    cmp_state_t state, next_state;
    logic signed [32:0] diff;
    logic [32:0] mag;

    // Widen by one bit so the difference of extremes cannot wrap
    always_comb begin
        diff = 33'(a) - 33'(b);
        mag = diff[32] ? 33'(-diff) : diff;
        next_state.below = mag < {1'b0, limit};
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign below = state.below;
endmodule : abs_diff_cmp
`default_nettype wire

// ===== core/pin_sync3.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Three-stage input synchroniser, change accepted when stages two and three agree
// ----------------------------------------
module pin_sync3 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } sync_state_t;

    sync_state_t state, next_state;

    // s1 only feeds s2; the filter looks at s2 and s3
    always_comb begin
        next_state = state;
        next_state.s1 = d;
        next_state.s2 = state.s1;
        next_state.s3 = state.s2;
        for (int i = 0; i < W; i++) begin
            if (state.s2[i] == state.s3[i]) begin
                next_state.q[i] = state.s3[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign q = state.q;
endmodule : pin_sync3
`default_nettype wire

// ===== core/servo_status_flag_outputs.sv
`timescale 1ns/100ps
`default_nettype none
module servo_status_flag_outputs (
    input wire logic clk,
    input wire logic rstn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Drive conditions, same clock
    input wire servo_flags_pkg::drive_cond_t cond,
    // Operator panel fault reset key, asynchronous pin
    input wire logic panel_key_pin,
    // Discrete outputs, high = closed
    output servo_flags_pkg::flags_t flag_out,
    output logic servo_enabled
);
    import servo_flags_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic abs_scale;
        logic no_hall;
        logic [1:0] settle_sel_cfg;   // written value
        logic [1:0] settle_sel;       // value in force since restart
        ctrl_mode_t mode;
        logic [31:0] motion_thresh;
        logic [31:0] match_band;
        logic [31:0] settle_window;
        logic [NUM_ALLOC-1:0] alloc;
        logic signed [31:0] speed_ref;
        logic signed [31:0] speed_act;
        logic signed [31:0] pos_err;
        logic fault_latched;
        logic sensor_on;
        logic servo_on;
        logic motion_raw;
        logic key_prev;               // filtered key level one cycle ago
        flags_t raw;
        flags_t out;
    } top_state_t;

    top_state_t state, next_state;
    logic key_sync;
    logic match_below;
    logic settle_below;
    logic [31:0] speed_mag;
    logic write_fire;
    logic read_fire;
    logic cmd_write;

    // ----------------------------------------
    // Panel key synchroniser and comparators
    // ----------------------------------------
    pin_sync3 #(.W(1)) u_key_sync (
        .clk(clk),
        .rstn(rstn),
        .d(panel_key_pin),
        .q(key_sync)
    );

    abs_diff_cmp u_match_cmp (
        .clk(clk),
        .rstn(rstn),
        .a(state.speed_ref),
        .b(state.speed_act),
        .limit(state.match_band),
        .below(match_below)
    );

    // Window is used here only; the loop never sees it
    abs_diff_cmp u_settle_cmp (
        .clk(clk),
        .rstn(rstn),
        .a(state.pos_err),
        .b(32'sh0000_0000),
        .limit(state.settle_window),
        .below(settle_below)
    );

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb begin
        next_state = state;
        // Zero-wait APB: answer in the access cycle
        write_fire = psel && penable && pwrite;
        read_fire = psel && penable && !pwrite;
        cmd_write = write_fire && (paddr == ADDR_COMMAND);
        next_state.pready = psel && !penable;
        next_state.pslverr = 1'b0;
        next_state.prdata = 32'h0000_0000;
        speed_mag = state.speed_act[31] ? 32'(-state.speed_act) : 32'(state.speed_act);

        // Setup-phase decode so the data is ready when pready goes high
        if (psel && !penable) begin
            case (paddr)
                ADDR_CONTROL: begin
                    next_state.prdata = {26'h0, 2'(state.mode), state.settle_sel_cfg, state.no_hall,
                                         state.abs_scale};
                end
                ADDR_STATUS: begin
                    next_state.prdata = {23'h0, state.servo_on, state.sensor_on, state.fault_latched,
                                         state.out};
                end
                ADDR_MOTION_THRESH: next_state.prdata = state.motion_thresh;
                ADDR_MATCH_BAND: next_state.prdata = state.match_band;
                ADDR_SETTLE_WINDOW: next_state.prdata = state.settle_window;
                ADDR_ALLOC: next_state.prdata = {27'h0, state.alloc};
                ADDR_COMMAND: next_state.prdata = 32'h0000_0000;
                ADDR_SPEED_REF: next_state.prdata = state.speed_ref;
                ADDR_SPEED_ACT: next_state.prdata = state.speed_act;
                ADDR_POS_ERR: next_state.prdata = state.pos_err;
                default: next_state.pslverr = 1'b1;
            endcase
        end

        // Register writes; out-of-range settings are clamped; all but settle select take effect next cycle
        if (write_fire) begin
            case (paddr)
                ADDR_CONTROL: begin
                    next_state.abs_scale = pwdata[CTL_ABS_SCALE];
                    next_state.no_hall = pwdata[CTL_NO_HALL];
                    next_state.settle_sel_cfg = pwdata[CTL_SETTLE_LO +: 2];
                    next_state.mode = ctrl_mode_t'(pwdata[CTL_MODE_LO +: 2]);
                end
                ADDR_MOTION_THRESH: begin
                    if (pwdata < MOTION_THRESH_MIN) begin
                        next_state.motion_thresh = MOTION_THRESH_MIN;
                    end else if (pwdata > MOTION_THRESH_MAX) begin
                        next_state.motion_thresh = MOTION_THRESH_MAX;
                    end else begin
                        next_state.motion_thresh = pwdata;
                    end
                end
                ADDR_MATCH_BAND: begin
                    next_state.match_band = (pwdata > MATCH_BAND_MAX) ? MATCH_BAND_MAX : pwdata;
                end
                ADDR_SETTLE_WINDOW: begin
                    next_state.settle_window = (pwdata > SETTLE_WINDOW_MAX) ? SETTLE_WINDOW_MAX : pwdata;
                end
                ADDR_ALLOC: next_state.alloc = pwdata[NUM_ALLOC-1:0];
                ADDR_SPEED_REF: next_state.speed_ref = pwdata;
                ADDR_SPEED_ACT: next_state.speed_act = pwdata;
                ADDR_POS_ERR: next_state.pos_err = pwdata;
                default: begin
                end
            endcase
        end
        if (read_fire) begin
            next_state.prdata = 32'h0000_0000;
        end

        // Host commands; sensor off is refused while the servo is on
        if (cmd_write && pwdata[CMD_SENSOR_ON]) begin
            next_state.sensor_on = 1'b1;
        end
        if (cmd_write && pwdata[CMD_SENSOR_OFF] && !state.servo_on) begin
            next_state.sensor_on = 1'b0;
        end
        if (cmd_write && pwdata[CMD_SERVO_ON]) begin
            next_state.servo_on = state.raw.drive_ready;
        end
        if (state.fault_latched || cond.power_block_active || !cond.main_power_on) begin
            next_state.servo_on = 1'b0;
        end

        // Fault latch: clear by command or key edge, a new fault wins the same cycle;
        // the edge looks at the filtered key level only, so bounce cannot clear twice
        next_state.key_prev = key_sync;
        if ((cmd_write && pwdata[CMD_FAULT_CLEAR]) || (key_sync && !state.key_prev)) begin
            next_state.fault_latched = 1'b0;
        end
        if (cond.fault_detect) begin
            next_state.fault_latched = 1'b1;
        end

        // Registered comparisons feed the flags one cycle later
        next_state.motion_raw = speed_mag >= state.motion_thresh;
        next_state.raw.fault_indicator = !state.fault_latched;
        next_state.raw.warning = cond.warning_detect;
        next_state.raw.motion_detected = state.motion_raw;
        next_state.raw.drive_ready = cond.main_power_on && !cond.power_block_active && !state.fault_latched
            && (!state.abs_scale || state.sensor_on) && (!state.no_hall || cond.polarity_done);
        next_state.raw.speed_match = (state.mode == MODE_SPEED) && match_below;
        case (state.settle_sel)
            2'h1: next_state.raw.position_settled = (state.mode == MODE_POSITION) && settle_below
                && cond.filtered_ref_zero;
            2'h2: next_state.raw.position_settled = (state.mode == MODE_POSITION) && settle_below
                && cond.raw_ref_zero;
            default: next_state.raw.position_settled = (state.mode == MODE_POSITION) && settle_below;
        endcase

        // Pin allocation; the fault pin is always present
        next_state.out.fault_indicator = state.raw.fault_indicator;
        next_state.out.warning = state.raw.warning && state.alloc[ALLOC_WARN];
        next_state.out.motion_detected = state.raw.motion_detected && state.alloc[ALLOC_MOTION];
        next_state.out.drive_ready = state.raw.drive_ready && state.alloc[ALLOC_READY];
        next_state.out.speed_match = state.raw.speed_match && state.alloc[ALLOC_MATCH];
        next_state.out.position_settled = state.raw.position_settled && state.alloc[ALLOC_SETTLED];
    end

    // ----------------------------------------
    // State register; settle select is taken from its written value only at restart
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state <= '0;
            state.settle_sel_cfg <= SETTLE_SEL_RST;
            state.settle_sel <= state.settle_sel_cfg;
            state.mode <= MODE_POSITION;
            state.motion_thresh <= MOTION_THRESH_RST;
            state.match_band <= MATCH_BAND_RST;
            state.settle_window <= SETTLE_WINDOW_RST;
            state.alloc <= ALLOC_RST;
        end else begin
            state <= next_state;
        end
    end

    assign prdata = state.prdata;
    assign pready = state.pready;
    assign pslverr = state.pslverr;
    assign flag_out = state.out;
    assign servo_enabled = state.servo_on;
endmodule : servo_status_flag_outputs
`default_nettype wire

// ===== bench/servo_status_flag_outputs_chk.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Port-level checker for the status flag block
// ----------------------------------------
module servo_status_flag_outputs_chk (
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire servo_flags_pkg::drive_cond_t cond,
    input wire logic panel_key_pin,
    input wire servo_flags_pkg::flags_t flag_out,
    input wire logic servo_enabled
);
    import servo_flags_pkg::*;
    // One clock domain, so clocking and reset are given once
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rstn);

    a_apb_zero_wait: assert property (psel && !penable |=> pready)
        else $error("pready missing in access cycle");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("pready outside an access phase");
    a_err_refused: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
        else $error("refused access returned data");
    a_cmd_reads_zero: assert property (pready && !pwrite && paddr == ADDR_COMMAND |-> prdata == 32'h0000_0000)
        else $error("command register read back nonzero");
    // Fault latch plus two output stages; a slower path would leave the contact closed too long
    a_fault_opens: assert property (cond.fault_detect |-> ##[2:3] !flag_out.fault_indicator)
        else $error("fault contact did not open");
    a_ready_needs_power: assert property (
        (!cond.main_power_on || cond.power_block_active) [*4] |-> !flag_out.drive_ready)
        else $error("ready without power");
    a_warn_quiet: assert property (!cond.warning_detect [*4] |-> !flag_out.warning)
        else $error("warning without cause");
    a_reset_clears: assert property (
        disable iff (1'b0) !rstn |=> flag_out == 6'h00 && !pready && !servo_enabled)
        else $error("outputs not cleared by reset");
endmodule : servo_status_flag_outputs_chk
`default_nettype wire

// ===== bench/host_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Host motion controller model
// ----------------------------------------
module host_ctrl_model (
    input wire logic clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    import servo_flags_pkg::*;
    logic [31:0] q;
    logic e;
    // Bus idles with no request pending
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
    end
    // One transfer; held until pready is seen at a rising edge, no wait count assumed
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rq, output logic er);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rq = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a; // Released lines stop showing the last value
        pwdata <= ~d;
    endtask : apb
    // Sensor enable only once the absolute position characters are taken in
    task sensor_enable();
        repeat (8) @(posedge clk);
        apb(1'b1, ADDR_COMMAND, 32'h0000_0002, q, e);
    endtask : sensor_enable
endmodule : host_ctrl_model
`default_nettype wire

// ===== bench/test_servo_status_flag_outputs.sv
`timescale 1ns/100ps
`default_nettype none
module test_servo_status_flag_outputs;
    import servo_flags_pkg::*;
    // Power on and polarity done; flag bit positions in flag_out
    localparam drive_cond_t C_OK = 8'h88;
    localparam int F_FAULT = 5, F_WARN = 4, F_MOT = 3, F_RDY = 2, F_MATCH = 1, F_SET = 0;
    logic clk;
    logic rstn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    drive_cond_t cond;
    logic panel_key_pin;
    flags_t flag_out;
    logic servo_enabled;
    logic [31:0] rd;
    logic er;
    int err_count;
    int n_tests;

    servo_status_flag_outputs DUT (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cond(cond),
        .panel_key_pin(panel_key_pin), .flag_out(flag_out), .servo_enabled(servo_enabled));
    host_ctrl_model host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    // ----------------------------------------
    // Clock and shared tasks
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task wr(input logic [11:0] a, input logic [31:0] d);
        host.apb(1'b1, a, d, rd, er);
    endtask : wr
    task rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
        host.apb(1'b0, a, 32'h0000_0000, rd, er);
        check(what, rd, exp);
    endtask : rdchk
    // Five cycles covers the longest pipeline of three, so the level is settled
    task fchk(input int i, input logic e);
        repeat (5) @(posedge clk);
        #1;
        check($sformatf("flag%0d", i), {31'h00000000, flag_out[i]}, {31'h00000000, e});
    endtask : fchk
    task wf(input logic [11:0] a, input logic [31:0] d, input int i, input logic e);
        wr(a, d);
        fchk(i, e);
    endtask : wf
    task cf(input drive_cond_t c, input int i, input logic e);
        @(posedge clk);
        cond <= c;
        fchk(i, e);
    endtask : cf
    task report_and_stop();
        $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : report_and_stop

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_reset();
        check("flags", {26'h0000000, flag_out}, 32'h0000_0020);
        rdchk("thresh", ADDR_MOTION_THRESH, MOTION_THRESH_RST);
        rdchk("band", ADDR_MATCH_BAND, MATCH_BAND_RST);
        rdchk("window", ADDR_SETTLE_WINDOW, SETTLE_WINDOW_RST);
        rdchk("command", ADDR_COMMAND, 32'h0000_0000);
        rdchk("unmapped", 12'hFFC, 32'h0000_0000);
        check("slverr", {31'h00000000, er}, 32'h0000_0001);
    endtask : t_reset
    task t_motion();
        wf(ADDR_ALLOC, 32'h0000_001F, F_MOT, 1'b0);
        wf(ADDR_SPEED_ACT, 32'h0000_0013, F_MOT, 1'b0);
        wf(ADDR_SPEED_ACT, 32'h0000_0014, F_MOT, 1'b1);
        wf(ADDR_SPEED_ACT, 32'hFFFF_FFEC, F_MOT, 1'b1);
        wf(ADDR_MOTION_THRESH, 32'h0000_2711, F_MOT, 1'b0);
        rdchk("thresh_max", ADDR_MOTION_THRESH, MOTION_THRESH_MAX);
        wf(ADDR_MOTION_THRESH, 32'h0000_0000, F_MOT, 1'b1);
        rdchk("thresh_min", ADDR_MOTION_THRESH, MOTION_THRESH_MIN);
        wf(ADDR_SPEED_ACT, 32'h0000_0000, F_MOT, 1'b0);
    endtask : t_motion
    // Band edges: a difference equal to the band must not match
    task t_match();
        wr(ADDR_CONTROL, 32'h0000_0010);
        wr(ADDR_SPEED_REF, 32'h0000_07D0);
        wf(ADDR_SPEED_ACT, 32'h0000_07C6, F_MATCH, 1'b0);
        wf(ADDR_SPEED_ACT, 32'h0000_07C7, F_MATCH, 1'b1);
        wf(ADDR_MATCH_BAND, 32'h0000_0065, F_MATCH, 1'b1);
        rdchk("band_max", ADDR_MATCH_BAND, MATCH_BAND_MAX);
        wf(ADDR_SPEED_ACT, 32'h0000_0834, F_MATCH, 1'b0);
        wf(ADDR_SPEED_ACT, 32'h0000_0833, F_MATCH, 1'b1);
        wf(ADDR_CONTROL, 32'h0000_0000, F_MATCH, 1'b0);
        wf(ADDR_CONTROL, 32'h0000_0020, F_MATCH, 1'b0);
    endtask : t_match
    task t_warn();
        cf(C_OK | 8'h10, F_WARN, 1'b1);
        wf(ADDR_ALLOC, 32'h0000_001E, F_WARN, 1'b0);
        wf(ADDR_ALLOC, 32'h0000_001F, F_WARN, 1'b1);
        cf(C_OK, F_WARN, 1'b0);
    endtask : t_warn
    // A clear sent while the cause persists must not close the contact
    task t_fault();
        cf(C_OK | 8'h20, F_FAULT, 1'b0);
        wf(ADDR_COMMAND, 32'h0000_0001, F_FAULT, 1'b0);
        cf(C_OK, F_FAULT, 1'b0);
        cf(C_OK, F_RDY, 1'b0);
        wf(ADDR_COMMAND, 32'h0000_0001, F_FAULT, 1'b1);
        cf(C_OK | 8'h20, F_FAULT, 1'b0);
        cf(C_OK, F_FAULT, 1'b0);
        @(posedge clk);
        panel_key_pin <= 1'b1;
        repeat (6) @(posedge clk);
        panel_key_pin <= 1'b0;
        cf(C_OK, F_FAULT, 1'b1);
    endtask : t_fault
    task t_ready();
        cf(C_OK, F_RDY, 1'b1);
        cf(C_OK | 8'h40, F_RDY, 1'b0);
        cf(8'h08, F_RDY, 1'b0);
        wr(ADDR_CONTROL, 32'h0000_0003);
        cf(C_OK, F_RDY, 1'b0);
        host.sensor_enable();
        fchk(F_RDY, 1'b1);
        cf(8'h80, F_RDY, 1'b0);
        cf(C_OK, F_RDY, 1'b1);
        wf(ADDR_COMMAND, 32'h0000_0008, F_RDY, 1'b1);
        // Sensor off is refused while the servo is on, accepted once it is off
        wf(ADDR_COMMAND, 32'h0000_0004, F_RDY, 1'b1);
        check("servo_on", {31'h00000000, servo_enabled}, 32'h0000_0001);
        cf(8'h08, F_RDY, 1'b0);
        check("servo_off", {31'h00000000, servo_enabled}, 32'h0000_0000);
        wr(ADDR_COMMAND, 32'h0000_0004);
        cf(C_OK, F_RDY, 1'b0);
    endtask : t_ready
    // Timing select only takes hold through a restart, so each setting is followed by one reset edge
    task t_settle();
        for (int s = 0; s < 3; s++) begin
            wr(ADDR_CONTROL, {28'h0000000, s[1:0], 2'h0});
            @(posedge clk);
            rstn <= 1'b0;
            @(posedge clk);
            rstn <= 1'b1;
            wr(ADDR_ALLOC, 32'h0000_001F);
            wr(ADDR_POS_ERR, 32'hFFFF_FFFA);
            for (int k = 0; k < 3; k++) begin
                cf(C_OK | {6'h00, k == 1, k == 2}, F_SET, s == 0 || s == k);
            end
        end
        cf(C_OK | 8'h03, F_SET, 1'b1);
        wf(ADDR_POS_ERR, 32'h0000_0007, F_SET, 1'b0);
        wf(ADDR_SETTLE_WINDOW, 32'h0000_0008, F_SET, 1'b1);
        check("motion_iso", {31'h00000000, flag_out[F_MOT]}, 32'h0000_0000);
        wf(ADDR_SETTLE_WINDOW, 32'h4000_0001, F_SET, 1'b1);
        rdchk("window_max", ADDR_SETTLE_WINDOW, SETTLE_WINDOW_MAX);
    endtask : t_settle

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        rstn = 1'b0;
        cond = 8'h00;
        panel_key_pin = 1'b0;
        err_count = 0;
        n_tests = 0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        fchk(F_FAULT, 1'b1);
        t_reset();
        t_motion();
        t_match();
        t_warn();
        t_fault();
        t_ready();
        t_settle();
        report_and_stop();
    end
    // Whole run is well under a thousand cycles; this cuts a hung handshake short
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        report_and_stop();
    end
endmodule : test_servo_status_flag_outputs

bind servo_status_flag_outputs servo_status_flag_outputs_chk u_chk (.clk(clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cond(cond), .panel_key_pin(panel_key_pin), .flag_out(flag_out), .servo_enabled(servo_enabled));
`default_nettype wire
